//--- src/ptec_pkg.sv
`default_nettype none

package ptec_pkg;

  // ****************************************
  // Bus and prescaler geometry
  // ****************************************
  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 32;
  localparam int          PRE_W            = 12;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [7:0]  OFF_MODE_BASE    = 8'h00;
  localparam logic [7:0]  OFF_DATA_BASE    = 8'h14;
  localparam logic [7:0]  OFF_STRIDE       = 8'h04;
  localparam logic [7:0]  OFF_T4_MATCH_LOW = 8'h24;
  localparam logic [7:0]  OFF_T4_MATCH_HI  = 8'h28;
  localparam logic [7:0]  OFF_COUNT        = 8'h2c;
  localparam logic [7:0]  OFF_T4_COUNT     = 8'h30;
  localparam logic [7:0]  OFF_FLAGS        = 8'h34;
  localparam logic [7:0]  OFF_EDGE_SEL     = 8'h38;
  localparam logic [7:0]  OFF_PSR          = 8'hf8;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int          MODE_RUN_BIT     = 3;
  localparam int          MODE_CAP_BIT     = 4;
  localparam int          MODE_CASC_BIT    = 5;
  localparam int          MODE_PWM_BIT     = 6;
  localparam int          PSR_EVA_BIT      = 4;
  localparam int          PSR_EVB_BIT      = 5;
  localparam int          PSR_CMP_BIT      = 7;
  localparam int          EDGE_FALL_BIT    = 0;
  localparam int          EDGE_RISE_BIT    = 1;
  localparam int          FLAG_EXT_LSB     = 8;
  localparam logic [2:0]  SEL_EXTERNAL     = 3'h7;
  localparam logic [1:0]  SEL_CASCADE      = 2'h3;

  // ****************************************
  // Prescale tap per clock select (tap k = fclk / 2^(k+1))
  // ****************************************
  localparam logic [6:0][3:0] T0_DIV_IDX = {4'hb, 4'h9, 4'h7, 4'h5, 4'h3, 4'h2, 4'h1};
  localparam logic [6:0][3:0] T1_DIV_IDX = {4'h0, 4'h0, 4'h0, 4'h0, 4'h3, 4'h1, 4'h0};
  localparam logic [6:0][3:0] T2_DIV_IDX = {4'ha, 4'h8, 4'h6, 4'h4, 4'h3, 4'h2, 4'h1};
  localparam logic [6:0][3:0] T3_DIV_IDX = {4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'h2, 4'h0};

  // ****************************************
  // Carriers and state
  // ****************************************
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } ptec_apb_req_t;

  typedef struct packed {
    logic [4:0][7:0]   mode;
    logic [3:0][7:0]   match_data;
    logic [15:0]       t4_match;
    logic [3:0][7:0]   count;
    logic [15:0]       t4_count;
    logic [3:0][7:0]   capture;
    logic [15:0]       t4_capture;
    logic [7:0]        psr;
    logic [9:0]        edge_sel;
    logic [4:0]        match_flag;
    logic [4:0]        ext_flag;
    logic [PRE_W-1:0]  prescale;
    logic              ev_a_prev;
    logic              ev_b_prev;
    logic [4:0]        cap_prev;
    logic              cmp_out;
    logic              cmp_oe;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } ptec_state_t;

  localparam ptec_state_t STATE_RESET = '0;

endpackage : ptec_pkg

`default_nettype wire

//--- src/ptec_top.sv
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module ptec_top (
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire ptec_pkg::ptec_apb_req_t apb_req,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  input  wire logic                  event_pin_a,
  input  wire logic                  event_pin_b,
  input  wire logic [4:0]            capture_edge_pin,
  output var  logic                  compare_output_pin,
  output var  logic                  compare_output_en,
  output var  logic [4:0]            match_interrupt_flag,
  output var  logic [4:0]            ext_interrupt_flag
);
  import ptec_pkg::*;

  ptec_state_t      s_reg;
  ptec_state_t      s_next;
  logic [PRE_W-1:0] pre_tick;

  // ****************************************
  // Prescale taps
  // ****************************************
  // Tap k pulses once every 2^(k+1) clocks, which folds the fixed
  // divide-by-two of the count path into the prescaler.
  genvar g;
  generate
    for (g = 0; g < PRE_W; g++) begin : g_tap
      assign pre_tick[g] = &s_reg.prescale[g:0];
    end
  endgenerate

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] slot_addr(input logic [7:0] base, input int idx);
    slot_addr = 8'(base + OFF_STRIDE * 8'(idx));
  endfunction

  // Two-bit selects map 11 onto the external code with no pin, so a stray
  // 11 without cascade simply stops that timer.
  function automatic logic [2:0] sel2(input logic [1:0] sel);
    sel2 = (sel == SEL_CASCADE) ? SEL_EXTERNAL : {1'b0, sel};
  endfunction

  function automatic logic src_tick(input logic [2:0]      sel,
                                    input logic [6:0][3:0] tbl,
                                    input logic            ext_ok,
                                    input logic            ext_rise,
                                    input logic [PRE_W-1:0] taps);
    if (sel == SEL_EXTERNAL) begin
      src_tick = ext_ok & ext_rise;
    end else begin
      src_tick = taps[tbl[sel]];
    end
  endfunction

  // Returns {match, next count}
  function automatic logic [16:0] step(input logic run,
                                       input logic cap_hit,
                                       input logic tk,
                                       input logic [15:0] c,
                                       input logic [15:0] d);
    if (!run) begin
      step = {1'b0, 16'h0000};
    end else if (cap_hit) begin
      step = {1'b0, 16'h0000};
    end else if (tk && (c == d)) begin
      step = {1'b1, 16'h0000};
    end else if (tk) begin
      step = {1'b0, 16'(c + 16'h0001)};
    end else begin
      step = {1'b0, c};
    end
  endfunction

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == OFF_PSR) || (a == OFF_FLAGS) || (a == OFF_EDGE_SEL) ||
              (a == OFF_T4_MATCH_LOW) || (a == OFF_T4_MATCH_HI) ||
              (a == OFF_COUNT) || (a == OFF_T4_COUNT);
    for (int i = 0; i < 5; i++) begin
      if (a == slot_addr(OFF_MODE_BASE, i)) reg_hit = 1'b1;
    end
    for (int i = 0; i < 4; i++) begin
      if (a == slot_addr(OFF_DATA_BASE, i)) reg_hit = 1'b1;
    end
  endfunction

  function automatic logic [31:0] reg_read(input ptec_state_t st, input logic [7:0] a);
    logic t4_cap;
    t4_cap   = st.mode[4][MODE_CAP_BIT];
    reg_read = 32'h0000_0000;
    if (a == OFF_PSR) begin
      reg_read = {24'h000000, st.psr};
    end else if (a == OFF_FLAGS) begin
      reg_read = {19'h0, st.ext_flag, 3'h0, st.match_flag};
    end else if (a == OFF_EDGE_SEL) begin
      reg_read = {22'h0, st.edge_sel};
    end else if (a == OFF_T4_MATCH_LOW) begin
      reg_read = {24'h000000, t4_cap ? st.t4_capture[7:0] : st.t4_match[7:0]};
    end else if (a == OFF_T4_MATCH_HI) begin
      reg_read = {24'h000000, t4_cap ? st.t4_capture[15:8] : st.t4_match[15:8]};
    end else if (a == OFF_COUNT) begin
      reg_read = st.count;
    end else if (a == OFF_T4_COUNT) begin
      reg_read = {16'h0000, st.t4_count};
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (a == slot_addr(OFF_MODE_BASE, i)) reg_read = {24'h000000, st.mode[i]};
      end
      for (int i = 0; i < 4; i++) begin
        if (a == slot_addr(OFF_DATA_BASE, i)) begin
          reg_read = {24'h000000, st.mode[i][MODE_CAP_BIT] ? st.capture[i] : st.match_data[i]};
        end
      end
    end
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic        wr;
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [4:0]  clr_match;
    logic [4:0]  clr_ext;
    logic [4:0]  set_match;
    logic [4:0]  cap_edge;
    logic [4:0]  tk;
    logic        ev_a_rise;
    logic        ev_b_rise;
    logic        casc;
    logic        cap16;
    logic [16:0] r;
    int          lo;
    int          hi;
    wr        = apb_req.psel & apb_req.penable & s_reg.pready & apb_req.pwrite;
    wa        = apb_req.paddr;
    wd        = apb_req.pwdata;
    clr_match = 5'h00;
    clr_ext   = 5'h00;
    set_match = 5'h00;
    cap_edge  = 5'h00;
    tk        = 5'h00;
    ev_a_rise = 1'b0;
    ev_b_rise = 1'b0;
    casc      = 1'b0;
    cap16     = 1'b0;
    r         = 17'h00000;
    lo        = 0;
    hi        = 0;
    s_next    = s_reg;

    s_next.prescale  = PRE_W'(s_reg.prescale + 1'b1);
    s_next.ev_a_prev = event_pin_a;
    s_next.ev_b_prev = event_pin_b;
    s_next.cap_prev  = capture_edge_pin;

    ev_a_rise = event_pin_a & ~s_reg.ev_a_prev;
    ev_b_rise = event_pin_b & ~s_reg.ev_b_prev;

    for (int i = 0; i < 5; i++) begin
      cap_edge[i] = (s_reg.edge_sel[2*i+EDGE_RISE_BIT] & capture_edge_pin[i] & ~s_reg.cap_prev[i]) |
                    (s_reg.edge_sel[2*i+EDGE_FALL_BIT] & ~capture_edge_pin[i] & s_reg.cap_prev[i]);
    end

    // ****************************************
    // APB slave: setup cycle loads answer, access cycle completes
    // ****************************************
    s_next.pready  = 1'b0;
    s_next.pslverr = 1'b0;
    if (apb_req.psel && !apb_req.penable) begin
      s_next.pready  = 1'b1;
      s_next.prdata  = apb_req.pwrite ? 32'h0000_0000 : reg_read(s_reg, wa);
      s_next.pslverr = ~reg_hit(wa);
    end
    if (wr) begin
      if (wa == OFF_PSR) begin
        s_next.psr = wd[7:0];
      end else if (wa == OFF_FLAGS) begin
        clr_match = wd[4:0];
        clr_ext   = wd[FLAG_EXT_LSB+4:FLAG_EXT_LSB];
      end else if (wa == OFF_EDGE_SEL) begin
        s_next.edge_sel = wd[9:0];
      end else if (wa == OFF_T4_MATCH_LOW) begin
        s_next.t4_match[7:0] = wd[7:0];
      end else if (wa == OFF_T4_MATCH_HI) begin
        s_next.t4_match[15:8] = wd[7:0];
      end else begin
        for (int i = 0; i < 5; i++) begin
          if (wa == slot_addr(OFF_MODE_BASE, i)) s_next.mode[i] = wd[7:0];
        end
        for (int i = 0; i < 4; i++) begin
          // writes always reach the data register
          if (wa == slot_addr(OFF_DATA_BASE, i)) s_next.match_data[i] = wd[7:0];
        end
      end
    end

    // ****************************************
    // Count sources
    // ****************************************
    // timer 0 to 4 ratios
    tk[0] = src_tick(s_reg.mode[0][2:0], T0_DIV_IDX, s_reg.psr[PSR_EVA_BIT], ev_a_rise, pre_tick);
    tk[1] = src_tick(sel2(s_reg.mode[1][1:0]), T1_DIV_IDX, 1'b0, 1'b0, pre_tick);
    tk[2] = src_tick(s_reg.mode[2][2:0], T2_DIV_IDX, s_reg.psr[PSR_EVB_BIT], ev_b_rise, pre_tick);
    tk[3] = src_tick(sel2(s_reg.mode[3][1:0]), T3_DIV_IDX, 1'b0, 1'b0, pre_tick);
    tk[4] = src_tick(s_reg.mode[4][2:0], T2_DIV_IDX, s_reg.psr[PSR_EVA_BIT], ev_a_rise, pre_tick);

    // ****************************************
    // Timer pairs
    // ****************************************
    // each pair decodes its own mode
    for (int p = 0; p < 2; p++) begin
      lo = 2 * p;
      hi = 2 * p + 1;
      // cascade needs select 11 and bit
      casc  = s_reg.mode[hi][MODE_CASC_BIT] && (s_reg.mode[hi][1:0] == SEL_CASCADE);
      // both capture bits for 16-bit capture
      cap16 = casc && s_reg.mode[hi][MODE_CAP_BIT] && s_reg.mode[lo][MODE_CAP_BIT];
      if (casc) begin
        // cascade uses lower clock, lower flag
        // lower byte low, upper byte high
        r = step(s_reg.mode[lo][MODE_RUN_BIT], cap16 & cap_edge[lo], tk[lo],
                 {s_reg.count[hi], s_reg.count[lo]},
                 {s_reg.match_data[hi], s_reg.match_data[lo]});
        if (cap16 && cap_edge[lo] && s_reg.mode[lo][MODE_RUN_BIT]) begin
          s_next.capture[lo] = s_reg.count[lo];
          s_next.capture[hi] = s_reg.count[hi];
        end
        s_next.count[lo] = r[7:0];
        s_next.count[hi] = r[15:8];
        set_match[lo]    = r[16];
      end else begin
        for (int k = 0; k < 2; k++) begin
          r = step(s_reg.mode[lo+k][MODE_RUN_BIT],
                   s_reg.mode[lo+k][MODE_CAP_BIT] & cap_edge[lo+k], tk[lo+k],
                   {8'h00, s_reg.count[lo+k]}, {8'h00, s_reg.match_data[lo+k]});
          if (s_reg.mode[lo+k][MODE_CAP_BIT] && cap_edge[lo+k] && s_reg.mode[lo+k][MODE_RUN_BIT]) begin
            s_next.capture[lo+k] = s_reg.count[lo+k];
          end
          s_next.count[lo+k] = r[7:0];
          set_match[lo+k]    = r[16];
        end
      end
    end

    // ****************************************
    // Timer 4
    // ****************************************
    // sixteen-bit match then clear
    r = step(s_reg.mode[4][MODE_RUN_BIT], s_reg.mode[4][MODE_CAP_BIT] & cap_edge[4], tk[4],
             s_reg.t4_count, s_reg.t4_match);
    if (s_reg.mode[4][MODE_CAP_BIT] && cap_edge[4] && s_reg.mode[4][MODE_RUN_BIT]) begin
      s_next.t4_capture = s_reg.t4_count;
    end
    s_next.t4_count = r[15:0];
    set_match[4]    = r[16];

    // ****************************************
    // Flags: a new event beats a clear in the same cycle
    // ****************************************
    s_next.match_flag = (s_reg.match_flag & ~clr_match) | set_match;
    s_next.ext_flag   = (s_reg.ext_flag & ~clr_ext) | cap_edge;

    // ****************************************
    // Compare output
    // ****************************************
    // pin only with bit 7, no PWM
    s_next.cmp_oe = s_reg.psr[PSR_CMP_BIT] & ~s_reg.mode[3][MODE_PWM_BIT];
    if (s_reg.cmp_oe && set_match[3]) begin
      s_next.cmp_out = ~s_reg.cmp_out;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // data registers reset to zero
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= STATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata               = s_reg.prdata;
  assign pready               = s_reg.pready;
  assign pslverr              = s_reg.pslverr;
  assign compare_output_pin   = s_reg.cmp_out;
  assign compare_output_en    = s_reg.cmp_oe;
  assign match_interrupt_flag = s_reg.match_flag;
  assign ext_interrupt_flag   = s_reg.ext_flag;

endmodule // ptec_top

`default_nettype wire

//--- test/ptec_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module ptec_monitor (
  input wire logic                    sys_clk,
  input wire logic                    rstn,
  input wire ptec_pkg::ptec_apb_req_t apb_req,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    compare_output_pin,
  input wire logic [4:0]              match_interrupt_flag,
  input wire logic [4:0]              ext_interrupt_flag
);
  import ptec_pkg::*;
  logic mapped;
  logic clr_wr;
  // Count words at 2c/30 are mapped for reads, so they never raise an error
  assign mapped = ((apb_req.paddr <= OFF_EDGE_SEL) && (apb_req.paddr[1:0] == 2'h0)) || (apb_req.paddr == OFF_PSR);
  assign clr_wr = apb_req.psel && apb_req.penable && apb_req.pwrite && (apb_req.paddr == OFF_FLAGS);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence setup_s;
    apb_req.psel && !apb_req.penable;
  endsequence

  pready_pulse_a: assert property (pready |=> !pready) else $error("pready held past one cycle");
  pready_answer_a: assert property (setup_s |=> pready) else $error("no answer after setup");
  err_unmapped_a: assert property (setup_s ##0 !mapped |=> pslverr) else $error("unmapped access not refused");
  err_mapped_a: assert property (setup_s ##0 mapped |=> !pslverr) else $error("mapped access refused");
  err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("error answer carries data");
  match_sticky_a: assert property (|($past(match_interrupt_flag) & ~match_interrupt_flag) |-> $past(clr_wr)) else $error("match flag fell without clear");
  ext_sticky_a: assert property (|($past(ext_interrupt_flag) & ~ext_interrupt_flag) |-> $past(clr_wr)) else $error("ext flag fell without clear");
  cmp_hold_a: assert property ($changed(compare_output_pin) |=> $stable(compare_output_pin)) else $error("compare level too short");
endmodule // ptec_monitor

bind ptec_top ptec_monitor ptec_monitor_i (
  .sys_clk(sys_clk), .rstn(rstn), .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .compare_output_pin(compare_output_pin), .match_interrupt_flag(match_interrupt_flag),
  .ext_interrupt_flag(ext_interrupt_flag));

`default_nettype wire

//--- test/ptec_pins.sv
`timescale 1ns/1ps
`default_nettype none

module ptec_pins (
  input  wire logic      sys_clk,
  output var  logic      event_pin_a,
  output var  logic      event_pin_b,
  output var  logic [4:0] capture_edge_pin
);
  initial begin
    event_pin_a = 1'b0;
    event_pin_b = 1'b0;
    capture_edge_pin = 5'h00;
  end

  // level held one clock at least
  task automatic events(input int pin, input int n, input int gap);
    for (int j = 0; j < 2 * n; j++) begin
      @(posedge sys_clk);
      if (pin == 0) event_pin_a <= ~event_pin_a;
      else event_pin_b <= ~event_pin_b;
      repeat (gap - 1) @(posedge sys_clk);
    end
  endtask

  // Settle time covers detect plus counter update
  task automatic cap_level(input int i, input logic v);
    @(posedge sys_clk);
    capture_edge_pin[i] <= v;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule // ptec_pins

`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import ptec_pkg::*;
  localparam int RT [4][7] = '{'{2, 4, 8, 32, 128, 512, 2048}, '{1, 2, 8, 0, 0, 0, 0},
                               '{2, 4, 8, 16, 64, 256, 1024}, '{1, 4, 16, 0, 0, 0, 0}};
  logic          sys_clk;
  logic          rstn;
  ptec_apb_req_t apb_req;
  logic [31:0]   prdata;
  logic          pready, pslverr, ev_a, ev_b, cmp_pin, cmp_en, er;
  logic [4:0]    cap_pin, mflag, xflag;
  logic [31:0]   rv;
  int            n_fail, cmp_count, cyc;

  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  ptec_top ptec_top_i (.sys_clk(sys_clk), .rstn(rstn), .apb_req(apb_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_pin_a(ev_a), .event_pin_b(ev_b), .capture_edge_pin(cap_pin),
    .compare_output_pin(cmp_pin), .compare_output_en(cmp_en), .match_interrupt_flag(mflag),
    .ext_interrupt_flag(xflag));
  ptec_pins ptec_pins_i (.sys_clk(sys_clk), .event_pin_a(ev_a), .event_pin_b(ev_b), .capture_edge_pin(cap_pin));

  // ****************************************
  // Shared tasks
  // ****************************************
  // ****************************************
  task close_out;
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task tmo;
    n_fail++;
    $display("MISMATCH wait expected done seen hang");
    close_out;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) tmo;
    rv = prdata;
    er = pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wflag(input int i, output int t);
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (mflag[i] !== 1'b1 && k < 20000);
    if (k >= 20000) tmo;
    t = cyc;
  endtask
  task automatic meas(input int i, input int e);
    int t0, t1;
    wr(OFF_FLAGS, 32'h1 << i);
    wflag(i, t0);
    wr(OFF_FLAGS, 32'h1 << i);
    wflag(i, t1);
    chk("interval", 32'(e), 32'(t1 - t0));
  endtask
  task automatic wedge(output int t);
    logic lv;
    int k;
    lv = cmp_pin;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (cmp_pin === lv && k < 200);
    if (k >= 200) tmo;
    t = cyc;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    chk("compare pin", 32'h0, 32'(cmp_pin));
    for (int i = 0; i < 6; i++) begin
      rd(OFF_DATA_BASE + 8'(4 * i));
      chk("data reset", 32'h0, rv);
    end
    rd(8'h3c);
    chk("unmapped err", 32'h1, 32'(er));
  endtask
  task t_ratio;
    int r, d;
    for (int i = 0; i < 4; i++) for (int s = 0; s < 7; s++) begin
      r = RT[i][s];
      if (r > 0) begin
        d = (r == 1) ? 3 : 1;
        wr(OFF_DATA_BASE + 8'(4 * i), 32'(d));
        wr(OFF_MODE_BASE + 8'(4 * i), 32'h8 | 32'(s));
        meas(i, 2 * r * (d + 1));
        wr(OFF_MODE_BASE + 8'(4 * i), 32'h0);
      end
    end
  endtask
  task t_casc;
    wr(OFF_DATA_BASE, 32'h1);
    wr(OFF_DATA_BASE + 8'h4, 32'h1);
    wr(OFF_DATA_BASE + 8'h8, 32'h1);
    wr(OFF_MODE_BASE + 8'h4, 32'h23);
    wr(OFF_MODE_BASE, 32'h8);
    wr(OFF_MODE_BASE + 8'h8, 32'h8);
    wr(OFF_FLAGS, 32'h1f1f);
    meas(0, 1032);
    chk("upper flag", 32'h0, 32'(mflag[1]));
    meas(2, 8);
    for (int i = 0; i < 3; i++) wr(OFF_MODE_BASE + 8'(4 * i), 32'h0);
    wr(OFF_T4_MATCH_LOW, 32'h0);
    wr(OFF_T4_MATCH_HI, 32'h1);
    wr(OFF_MODE_BASE + 8'h10, 32'h8);
    meas(4, 1028);
    wr(OFF_MODE_BASE + 8'h10, 32'h0);
  endtask
  task t_event;
    int i;
    for (int k = 0; k < 2; k++) begin
      i = 2 * k;
      wr(OFF_PSR, 32'h0);
      wr(OFF_DATA_BASE + 8'(4 * i), 32'h3);
      wr(OFF_MODE_BASE + 8'(4 * i), 32'hf);
      ptec_pins_i.events(k, 4, 1 + 2 * k);
      repeat (3) @(posedge sys_clk);
      rd(OFF_COUNT);
      chk("gated count", 32'h0, 32'(rv[8*i +: 8]));
      wr(OFF_PSR, 32'h10 << k);
      wr(OFF_FLAGS, 32'h1f);
      ptec_pins_i.events(k, 3, 1 + 2 * k);
      repeat (3) @(posedge sys_clk);
      rd(OFF_COUNT);
      chk("event count", 32'h3, 32'(rv[8*i +: 8]));
      chk("early flag", 32'h0, 32'(mflag[i]));
      ptec_pins_i.events(k, 1, 1 + 2 * k);
      repeat (3) @(posedge sys_clk);
      chk("event flag", 32'h1, 32'(mflag[i]));
      wr(OFF_MODE_BASE + 8'(4 * i), 32'h0);
    end
  endtask
  task t_cap;
    int k;
    wr(OFF_EDGE_SEL, 32'h2);
    wr(OFF_DATA_BASE, 32'hff);
    wr(OFF_FLAGS, 32'h1f00);
    wr(OFF_MODE_BASE, 32'h1e);
    k = 0;
    do begin
      rd(OFF_COUNT);
      k++;
    end while (rv[7:0] !== 8'h2 && k < 4000);
    if (k >= 4000) tmo;
    ptec_pins_i.cap_level(0, 1'b1);
    chk("ext flag", 32'h1, 32'(xflag[0]));
    rd(OFF_DATA_BASE);
    chk("capture", 32'h2, rv);
    rd(OFF_COUNT);
    chk("count cleared", 32'h0, 32'(rv[7:0]));
    wr(OFF_DATA_BASE, 32'h55);
    rd(OFF_DATA_BASE);
    chk("capture read", 32'h2, rv);
    wr(OFF_FLAGS, 32'h100);
    ptec_pins_i.cap_level(0, 1'b0);
    chk("fall ignored", 32'h0, 32'(xflag[0]));
    wr(OFF_EDGE_SEL, 32'h1);
    ptec_pins_i.cap_level(0, 1'b1);
    chk("rise ignored", 32'h0, 32'(xflag[0]));
    ptec_pins_i.cap_level(0, 1'b0);
    chk("fall flag", 32'h1, 32'(xflag[0]));
    wr(OFF_MODE_BASE, 32'h0);
  endtask
  task t_cap16;
    int k;
    wr(OFF_EDGE_SEL, 32'h30);
    wr(OFF_DATA_BASE + 8'h8, 32'hff);
    wr(OFF_DATA_BASE + 8'hc, 32'hff);
    wr(OFF_MODE_BASE + 8'hc, 32'h33);
    wr(OFF_MODE_BASE + 8'h8, 32'h18);
    wr(OFF_FLAGS, 32'h1f1f);
    k = 0;
    do begin
      rd(OFF_COUNT);
      k++;
    end while (rv[31:24] !== 8'h1 && k < 1000);
    if (k >= 1000) tmo;
    ptec_pins_i.cap_level(2, 1'b1);
    chk("rise flag", 32'h1, 32'(xflag[2]));
    rd(OFF_DATA_BASE + 8'hc);
    chk("capture high", 32'h1, rv);
    rd(OFF_COUNT);
    chk("count16 cleared", 32'h0, 32'(rv[31:24]));
    wr(OFF_FLAGS, 32'h400);
    ptec_pins_i.cap_level(2, 1'b0);
    chk("both edges", 32'h1, 32'(xflag[2]));
    wr(OFF_MODE_BASE + 8'h8, 32'h0);
    wr(OFF_MODE_BASE + 8'hc, 32'h0);
  endtask
  task t_cmp;
    int t0, t1, t2;
    wr(OFF_DATA_BASE + 8'hc, 32'h1);
    wr(OFF_MODE_BASE + 8'hc, 32'h8);
    chk("enable off", 32'h0, 32'(cmp_en));
    wr(OFF_PSR, 32'h80);
    wedge(t0);
    wedge(t1);
    wedge(t2);
    chk("enable on", 32'h1, 32'(cmp_en));
    chk("high time", 32'h4, 32'(t1 - t0));
    chk("low time", 32'h4, 32'(t2 - t1));
    wr(OFF_MODE_BASE + 8'hc, 32'h48);
    repeat (2) @(posedge sys_clk);
    chk("pwm blocks", 32'h0, 32'(cmp_en));
  endtask

  initial begin
    rstn = 1'b0;
    apb_req = '0;
    n_fail = 0;
    cmp_count = 0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset;
    t_ratio;
    t_casc;
    t_event;
    t_cap;
    t_cap16;
    t_cmp;
    close_out;
  end
endmodule // testbench

`default_nettype wire
